/* hp_pkg.sv */
package hp_pkg;
   localparam int ADDR_W       = 11;
   localparam int DATA_W       = 8;
   localparam int CHAN_W       = 4;
   localparam int FIFO_DEPTH   = 16;
   localparam int DRIVE_BIT    = 6;
   localparam logic [10:0] MAIN_CTRL_ADDR = 11'h000;
   localparam logic [10:0] IRQ_FIFO_ADDR  = 11'h001;
   localparam logic [7:0]  MAIN_CTRL_RST  = 8'h00;
   localparam logic [7:0]  FIFO_EMPTY_VAL = 8'h00;
   localparam logic [7:0]  ENTRY_VALID    = 8'h80;
endpackage

/* hp_evt_if.sv */
`timescale 1ns/1ps
interface hp_evt_if;
   logic       push;
   logic [3:0] chan;
   logic       pop;
   logic       empty;
   logic [3:0] head;
   modport owner (input push, input chan, input pop, output empty, output head);
   modport user  (output push, output chan, output pop, input empty, input head);
endinterface

/* hp_irq_fifo.sv */
`timescale 1ns/1ps
module hp_irq_fifo
   import hp_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic sys_clk,
   input  wire logic resetn,
   hp_evt_if.owner   evt
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][CHAN_W-1:0] mem;
      logic [PW-1:0]                wp;
      logic [PW-1:0]                rp;
      logic [PW:0]                  cnt;
   } fifo_s;

   fifo_s st_r;
   fifo_s st_nxt;

   // A push into a full queue is dropped unless a pop happens in the same cycle; a pop on an empty queue does nothing.
   always_comb
   begin
      st_nxt = st_r;
      if (evt.pop && st_r.cnt != '0)
      begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      if (evt.push && (st_r.cnt != (PW+1)'(DEPTH) || evt.pop))
      begin
         st_nxt.mem[st_r.wp] = evt.chan;
         st_nxt.wp = st_r.wp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt
                 + (PW+1)'(st_nxt.wp != st_r.wp)
                 - (PW+1)'(st_nxt.rp != st_r.rp);
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign evt.empty = (st_r.cnt == '0);
   assign evt.head  = st_r.mem[st_r.rp];
endmodule

/* echo_canceller_host_port.sv */
`timescale 1ns/1ps
// Function
// - Interrupt request output pulls low whenever any channel raises an interrupt.
// - Interrupt request releases only after every queued entry has been read out.
// - Reads and writes happen only while strobe and select are both low.
// - Direction input chooses read (data out) or write (data in).
// - Transfer acknowledge goes low when the current transfer has completed.
// - Serial outputs drive only when gate pin and control bit 6 are high.
// - Serial outputs float when either gate pin or control bit 6 is low.
module echo_canceller_host_port
   import hp_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  host_strobe_n,
   input  wire logic                  host_select_n,
   input  wire logic                  host_read_write,
   input  wire logic [ADDR_W-1:0]     host_address_bus,
   input  wire logic [DATA_W-1:0]     host_data_bus_in,
   output logic      [DATA_W-1:0]     host_data_bus_out,
   output logic                       host_data_bus_oe,
   output logic                       transfer_ack_n_out,
   output logic                       transfer_ack_n_oe,
   output logic                       irq_n_out,
   output logic                       irq_n_oe,
   input  wire logic                  output_drive_gate,
   input  wire logic                  chan_event,
   input  wire logic [CHAN_W-1:0]     chan_event_id,
   output logic                       pcm_out_enable,
   output logic      [DATA_W-1:0]     main_ctrl
);
   typedef struct packed {
      logic [1:0]        strb_s;
      logic [1:0]        sel_s;
      logic [1:0]        rw_s;
      logic [1:0]        gate_s;
      logic              busy;
      logic [DATA_W-1:0] ctrl;
      logic [DATA_W-1:0] dout;
      logic              doe;
      logic              ack_oe;
      logic              irq_oe;
      logic              pcm_en;
   } port_s;

   port_s st_r;
   port_s st_nxt;
   hp_evt_if evt ();

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      hit = (a == r);
   endfunction

   logic access;

   hp_irq_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo
   (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .evt     (evt.owner)
   );

   // Address and write data are sampled only after the synchronised strobe
   // has settled, so the host holds them stable through the access.
   assign access   = !st_r.strb_s[1] && !st_r.sel_s[1];
   assign evt.push = chan_event;
   assign evt.chan = chan_event_id;
   assign evt.pop  = access && !st_r.busy && st_r.rw_s[1]
                     && hit(host_address_bus, IRQ_FIFO_ADDR) && !evt.empty;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.strb_s = {st_r.strb_s[0], host_strobe_n};
      st_nxt.sel_s  = {st_r.sel_s[0], host_select_n};
      st_nxt.rw_s   = {st_r.rw_s[0], host_read_write};
      st_nxt.gate_s = {st_r.gate_s[0], output_drive_gate};
      if (access && !st_r.busy)
      begin
         st_nxt.busy   = 1'b1;
         st_nxt.ack_oe = 1'b1;
         if (st_r.rw_s[1])
         begin
            st_nxt.doe = 1'b1;
            if (hit(host_address_bus, MAIN_CTRL_ADDR))
            begin
               st_nxt.dout = st_r.ctrl;
            end
            else if (hit(host_address_bus, IRQ_FIFO_ADDR))
            begin
               st_nxt.dout = evt.empty ? FIFO_EMPTY_VAL
                                       : (ENTRY_VALID | DATA_W'(evt.head));
            end
            else
            begin
               st_nxt.dout = '0;
            end
         end
         else if (hit(host_address_bus, MAIN_CTRL_ADDR))
         begin
            st_nxt.ctrl = host_data_bus_in;
         end
      end
      else if (!access)
      begin
         st_nxt.busy   = 1'b0;
         st_nxt.ack_oe = 1'b0;
         st_nxt.doe    = 1'b0;
      end
      st_nxt.irq_oe = !evt.empty;
      st_nxt.pcm_en = st_r.gate_s[1] && st_r.ctrl[DRIVE_BIT];
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r      <= '0;
         st_r.strb_s <= 2'h3;
         st_r.sel_s  <= 2'h3;
         st_r.ctrl   <= MAIN_CTRL_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign host_data_bus_out  = st_r.dout;
   assign host_data_bus_oe   = st_r.doe;
   assign transfer_ack_n_out = 1'b0;
   assign transfer_ack_n_oe  = st_r.ack_oe;
   assign irq_n_out          = 1'b0;
   assign irq_n_oe           = st_r.irq_oe;
   assign pcm_out_enable     = st_r.pcm_en;
   assign main_ctrl          = st_r.ctrl;

   a_irq_follows_fifo: assert property (@(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> irq_n_oe == !$past(evt.empty))
      else $error("irq enable does not follow fifo state");
   a_irq_held_pending: assert property (@(posedge sys_clk) disable iff (!resetn)
      !evt.empty ##1 !evt.empty |-> irq_n_oe)
      else $error("irq released with entries pending");
   a_ack_needs_access: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(transfer_ack_n_oe) |-> $past(access))
      else $error("ack without strobe and select");
   a_ack_on_access: assert property (@(posedge sys_clk) disable iff (!resetn)
      access ##1 access |-> transfer_ack_n_oe)
      else $error("ack missing during access");
   a_ack_release: assert property (@(posedge sys_clk) disable iff (!resetn)
      !access |=> !transfer_ack_n_oe && !host_data_bus_oe)
      else $error("ack not released");
   a_read_drives_bus: assert property (@(posedge sys_clk) disable iff (!resetn)
      host_data_bus_oe |-> transfer_ack_n_oe)
      else $error("data driven outside an access");
   a_pcm_enable_and: assert property (@(posedge sys_clk) disable iff (!resetn)
      1'b1 |=> pcm_out_enable == ($past(st_r.gate_s[1]) && $past(main_ctrl[DRIVE_BIT])))
      else $error("pcm enable not the and of gate and bit");
   a_pcm_float: assert property (@(posedge sys_clk) disable iff (!resetn)
      !main_ctrl[DRIVE_BIT] |=> !pcm_out_enable)
      else $error("pcm driven with bit low");
endmodule

/* host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model
   import hp_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              ack_oe,
   input  wire logic              data_oe,
   input  wire logic [DATA_W-1:0] rdata,
   output logic                   strobe_n,
   output logic                   select_n,
   output logic                   read_write,
   output logic      [ADDR_W-1:0] addr,
   output logic      [DATA_W-1:0] wdata
);
   // The acknowledge pin has a pull-up, so it is high unless the port drives it.
   wire logic ack_pin = ack_oe ? 1'b0 : 1'b1;
   initial
   begin
      strobe_n = 1'b1;
      select_n = 1'b1;
      read_write = 1'b1;
      addr = '0;
      wdata = '0;
   end
   // One access: held until the acknowledge is seen low or 12 cycles pass, then released.
   task automatic xfer(input logic sel_n, input logic rd, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                       output logic got);
      got = 1'b0;
      q = 8'hzz;
      @(posedge sys_clk);
      select_n <= sel_n;
      strobe_n <= 1'b0;
      read_write <= rd;
      addr <= a;
      wdata <= d;
      for (int n = 0; n < 12 && !got; n++)
      begin
         @(posedge sys_clk);
         got = (ack_pin === 1'b0);
         if (got)
            q = data_oe ? rdata : 8'hzz;
      end
      strobe_n <= 1'b1;
      select_n <= 1'b1;
      // Address and write data show the inverse of their last value, never a stale copy; read_write keeps its value.
      addr <= ~a;
      wdata <= ~d;
      for (int n = 0; n < 12 && ack_pin !== 1'b1; n++)
         @(posedge sys_clk);
   endtask
endmodule

/* echo_canceller_host_port_tb.sv */
`timescale 1ns/1ps
module echo_canceller_host_port_tb;
   import hp_pkg::*;
   logic              sys_clk = 1'b0;
   logic              resetn = 1'b0;
   logic              strobe_n, select_n, read_write, gate = 1'b0, chan_event = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, dout, ctrl, q;
   logic [CHAN_W-1:0] chan_id = '0;
   logic              doe, ack_o, ack_oe, irq_o, irq_oe, pcm_en, got;
   int                failures = 0;
   int                comparisons = 0;
   always #12.5 sys_clk = ~sys_clk;
   host_bus_model i_host (.sys_clk(sys_clk), .ack_oe(ack_oe), .data_oe(doe), .rdata(dout),
      .strobe_n(strobe_n), .select_n(select_n), .read_write(read_write), .addr(addr),
      .wdata(wdata));
   echo_canceller_host_port i_dut (.sys_clk(sys_clk), .resetn(resetn),
      .host_strobe_n(strobe_n), .host_select_n(select_n), .host_read_write(read_write),
      .host_address_bus(addr), .host_data_bus_in(wdata), .host_data_bus_out(dout),
      .host_data_bus_oe(doe), .transfer_ack_n_out(ack_o), .transfer_ack_n_oe(ack_oe),
      .irq_n_out(irq_o), .irq_n_oe(irq_oe), .output_drive_gate(gate),
      .chan_event(chan_event), .chan_event_id(chan_id), .pcm_out_enable(pcm_en),
      .main_ctrl(ctrl));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic t_gating;
      for (int i = 0; i < 4; i++)
      begin
         i_host.xfer(1'b1 ^ 1'b1, 1'b0, MAIN_CTRL_ADDR, 8'(i[0]) << DRIVE_BIT, q, got);
         chk("write ack", 8'h01, {7'h00, got});
         gate <= i[1];
         repeat (4) @(posedge sys_clk);
         chk("pcm enable", {7'h00, i[0] & i[1]}, {7'h00, pcm_en});
         i_host.xfer(1'b0, 1'b1, MAIN_CTRL_ADDR, 8'h00, q, got);
         chk("ctrl read", 8'(i[0]) << DRIVE_BIT, q);
      end
   endtask
   task automatic t_ignored;
      i_host.xfer(1'b1, 1'b0, MAIN_CTRL_ADDR, 8'hff, q, got);
      chk("no ack deselected", 8'h00, {7'h00, got});
      chk("ctrl kept", 8'h40, ctrl);
      i_host.xfer(1'b0, 1'b0, 11'h7ff, 8'h00, q, got);
      i_host.xfer(1'b0, 1'b1, 11'h7ff, 8'h00, q, got);
      chk("unmapped read", 8'h00, q);
      chk("ctrl after unmapped", 8'h40, ctrl);
   endtask
   task automatic t_irq;
      @(posedge sys_clk);
      chan_event <= 1'b1;
      chan_id <= 4'h3;
      @(posedge sys_clk);
      chan_id <= 4'h9;
      @(posedge sys_clk);
      chan_event <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("irq raised", 8'h01, {7'h00, irq_oe});
      i_host.xfer(1'b0, 1'b1, IRQ_FIFO_ADDR, 8'h00, q, got);
      chk("first entry", ENTRY_VALID | 8'h03, q);
      chk("irq held", 8'h01, {7'h00, irq_oe});
      i_host.xfer(1'b0, 1'b1, IRQ_FIFO_ADDR, 8'h00, q, got);
      chk("second entry", ENTRY_VALID | 8'h09, q);
      repeat (3) @(posedge sys_clk);
      chk("irq released", 8'h00, {7'h00, irq_oe});
      i_host.xfer(1'b0, 1'b1, IRQ_FIFO_ADDR, 8'h00, q, got);
      chk("empty fifo", FIFO_EMPTY_VAL, q);
   endtask
   task automatic stop_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk("ctrl reset", MAIN_CTRL_RST, ctrl);
      t_gating();
      t_ignored();
      t_irq();
      stop_test();
   end
endmodule
